/* File: common/ppn_pkg.sv */
package ppn_pkg;

   // Bus widths
   localparam int ADDR_W = 28;
   localparam int DATA_W = 8;
   localparam int NUM_GRP = 4;
   localparam int GRP_W = 4;
   localparam int SEL_W = 2;

   // Byte addresses
   localparam logic [ADDR_W-1:0] ADDR_POD_HI = 28'h5ffffc2;
   localparam logic [ADDR_W-1:0] ADDR_POD_LO = 28'h5ffffc3;
   localparam logic [ADDR_W-1:0] ADDR_TRIG_SEL = 28'h5fffff1;
   localparam logic [ADDR_W-1:0] ADDR_EN_HI = 28'h5fffff2;
   localparam logic [ADDR_W-1:0] ADDR_EN_LO = 28'h5fffff3;
   localparam logic [ADDR_W-1:0] ADDR_ND_HI_MAIN = 28'h5fffff4;
   localparam logic [ADDR_W-1:0] ADDR_ND_LO_MAIN = 28'h5fffff5;
   localparam logic [ADDR_W-1:0] ADDR_ND_HI_ALT = 28'h5fffff6;
   localparam logic [ADDR_W-1:0] ADDR_ND_LO_ALT = 28'h5fffff7;

   // Field positions within a next-data byte
   localparam int NIB_UP_LSB = 4;
   localparam int NIB_LO_LSB = 0;

   // Values after reset and fixed read values
   localparam logic [15:0] RST_POD = 16'h0000;
   localparam logic [7:0] RST_ND = 8'h00;
   localparam logic [15:0] RST_EN = 16'h0000;
   localparam logic [7:0] RST_TRIG = 8'hff;
   localparam logic [7:0] RSVD_BYTE = 8'hff;
   localparam logic [3:0] RSVD_NIB = 4'hf;
   localparam logic [7:0] RDATA_IDLE = 8'h00;

   // One register-port request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } ppn_bus_t;

   // A pair of next-data byte lanes, upper pair first
   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } ppn_pair16_t;

endpackage

/* File: logic/ppn_trig_sel.sv */
`timescale 1ns/1ps
module ppn_trig_sel
   import ppn_pkg::*;
(
   // Trigger selection
   input wire logic [NUM_GRP*SEL_W-1:0] sel,
   // Compare-match pulses from the timer
   input wire logic [NUM_GRP-1:0] match,
   // Per-group transfer strobe
   output logic [NUM_GRP-1:0] fire
);

   genvar g;
   generate
      for (g = 0; g < NUM_GRP; g++) begin : g_grp
         // Code 00..11 picks timer channel 0..3
         assign fire[g] = match[sel[g*SEL_W +: SEL_W]];
      end
   endgenerate

endmodule

/* File: logic/ppn_pair_regs.sv */
`timescale 1ns/1ps
module ppn_pair_regs
   import ppn_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Write requests
   input wire logic wr_main,
   input wire logic wr_alt,
   input wire logic [7:0] wdata,
   // Both groups of the pair use one trigger
   input wire logic same_trig,
   // Stored next data and read views
   output logic [7:0] next_data,
   output logic [7:0] rd_main,
   output logic [7:0] rd_alt
);

   logic [7:0] data_r;

   // Standby needs no term: writes are already gated off upstream
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         data_r <= RST_ND;
      end else if (same_trig) begin
         // Whole byte at the main address, alternate ignored
         if (wr_main) begin
            data_r <= wdata;
         end
      end else begin
         // Upper nibble at main, lower nibble at alternate
         if (wr_main) begin
            data_r[NIB_UP_LSB +: GRP_W] <= wdata[NIB_UP_LSB +: GRP_W];
         end
         if (wr_alt) begin
            data_r[NIB_LO_LSB +: GRP_W] <= wdata[NIB_LO_LSB +: GRP_W];
         end
      end
   end

   assign next_data = data_r;

   // Read layout follows the trigger pairing
   always_comb begin
      if (same_trig) begin
         rd_main = data_r;
         rd_alt = RSVD_BYTE;
      end else begin
         rd_main = {data_r[NIB_UP_LSB +: GRP_W], RSVD_NIB};
         rd_alt = {RSVD_NIB, data_r[NIB_LO_LSB +: GRP_W]};
      end
   end

endmodule

/* File: logic/ppn_pattern_regs.sv */
// Operation
// - A 16-bit output data register holds all four group outputs.
// - Output bits enabled for pattern output ignore software writes, stay readable.
// - Low-pair next data copies into output bits 7-0 on its selected match.
// - Low-pair next data resets to zero and is held in standby.
// - Next-data address layout depends on whether a pair shares one trigger.
// - Shared low trigger: whole byte at main address, group 1 high nibble.
// - Shared low trigger: alternate low address reads ones, ignores writes.
// - Split low trigger: group 1 upper at main, group 0 lower at alternate.
// - High-pair next data copies into output bits 15-8 on its match.
// - High-pair next data resets to zero and is held in standby.
// - Shared high trigger: whole byte at main address, group 3 high nibble.
// - Shared high trigger: alternate high address reads ones, ignores writes.
// - Split high trigger: group 3 upper at main, group 2 lower at alternate.
// - Two-bit select picks timer channel 0 to 3; channel 3 after reset.
// - Bits without next-data enable get no transfer on a match.
`timescale 1ns/1ps
module ppn_pattern_regs
   import ppn_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // Register port
   input wire logic BUS_RD,
   input wire logic BUS_WR,
   input wire logic [ADDR_W-1:0] BUS_ADDR,
   input wire logic [DATA_W-1:0] BUS_WDATA,
   output logic [DATA_W-1:0] BUS_RDATA,
   // Timer compare-match pulses, channel 3 down to 0
   input wire logic [NUM_GRP-1:0] CMP_MATCH,
   // Standby freezes all contents
   input wire logic STANDBY,
   // Pattern output
   output logic [15:0] PATTERN_OUT
);

   ppn_bus_t bus;
   logic active;
   logic wr_pod_hi;
   logic wr_pod_lo;
   logic wr_trig;
   logic wr_en_hi;
   logic wr_en_lo;
   logic wr_nd_hi_main;
   logic wr_nd_hi_alt;
   logic wr_nd_lo_main;
   logic wr_nd_lo_alt;
   logic [15:0] port_output_data_r;
   logic [15:0] port_output_data_nxt;
   ppn_pair16_t next_enable_r;
   logic [7:0] trigger_select_r;
   logic same_trig_lo;
   logic same_trig_hi;
   logic [NUM_GRP-1:0] match_act;
   logic [NUM_GRP-1:0] fire;
   ppn_pair16_t next_data;
   logic [7:0] rd_lo_main;
   logic [7:0] rd_lo_alt;
   logic [7:0] rd_hi_main;
   logic [7:0] rd_hi_alt;
   logic [15:0] grp_mask;
   logic [15:0] xfer_mask;
   logic [15:0] wr_mask;
   logic [15:0] wd16;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;

   assign bus = '{rd: BUS_RD, wr: BUS_WR, addr: BUS_ADDR, wdata: BUS_WDATA};
   assign active = !STANDBY;

   // Write decode, nothing accepted in standby
   assign wr_pod_hi = bus.wr && active && (bus.addr == ADDR_POD_HI);
   assign wr_pod_lo = bus.wr && active && (bus.addr == ADDR_POD_LO);
   assign wr_trig = bus.wr && active && (bus.addr == ADDR_TRIG_SEL);
   assign wr_en_hi = bus.wr && active && (bus.addr == ADDR_EN_HI);
   assign wr_en_lo = bus.wr && active && (bus.addr == ADDR_EN_LO);
   assign wr_nd_hi_main = bus.wr && active && (bus.addr == ADDR_ND_HI_MAIN);
   assign wr_nd_hi_alt = bus.wr && active && (bus.addr == ADDR_ND_HI_ALT);
   assign wr_nd_lo_main = bus.wr && active && (bus.addr == ADDR_ND_LO_MAIN);
   assign wr_nd_lo_alt = bus.wr && active && (bus.addr == ADDR_ND_LO_ALT);

   // Trigger select, channel 3 for every group after reset
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         trigger_select_r <= RST_TRIG;
      end else if (wr_trig) begin
         trigger_select_r <= bus.wdata;
      end
   end

   // Per-bit next-data enables
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         next_enable_r <= RST_EN;
      end else begin
         if (wr_en_hi) begin
            next_enable_r.hi <= bus.wdata;
         end
         if (wr_en_lo) begin
            next_enable_r.lo <= bus.wdata;
         end
      end
   end

   // Pair sharing decides the next-data layout
   assign same_trig_lo = trigger_select_r[3:2] == trigger_select_r[1:0];
   assign same_trig_hi = trigger_select_r[7:6] == trigger_select_r[5:4];

   assign match_act = CMP_MATCH & {NUM_GRP{active}};

   ppn_trig_sel u_trig_sel (
      .sel(trigger_select_r),
      .match(match_act),
      .fire(fire)
   );

   // Groups 1 and 0
   ppn_pair_regs u_low_pair (
      .clk(CLK),
      .resetn(RESETN),
      .wr_main(wr_nd_lo_main),
      .wr_alt(wr_nd_lo_alt),
      .wdata(bus.wdata),
      .same_trig(same_trig_lo),
      .next_data(next_data.lo),
      .rd_main(rd_lo_main),
      .rd_alt(rd_lo_alt)
   );

   // Groups 3 and 2
   ppn_pair_regs u_high_pair (
      .clk(CLK),
      .resetn(RESETN),
      .wr_main(wr_nd_hi_main),
      .wr_alt(wr_nd_hi_alt),
      .wdata(bus.wdata),
      .same_trig(same_trig_hi),
      .next_data(next_data.hi),
      .rd_main(rd_hi_main),
      .rd_alt(rd_hi_alt)
   );

   // Nibble mask of each firing group
   genvar g;
   generate
      for (g = 0; g < NUM_GRP; g++) begin : g_mask
         assign grp_mask[g*GRP_W +: GRP_W] = {GRP_W{fire[g]}};
      end
   endgenerate

   // Transfer only into enabled bits of firing groups
   assign xfer_mask = grp_mask & next_enable_r;
   // Software reaches only bits not enabled for pattern output
   assign wr_mask = {{8{wr_pod_hi}}, {8{wr_pod_lo}}} & ~next_enable_r;
   assign wd16 = {bus.wdata, bus.wdata};

   always_comb begin
      port_output_data_nxt = (port_output_data_r & ~(xfer_mask | wr_mask))
         | (next_data & xfer_mask) | (wd16 & wr_mask);
   end

   // Output data register
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         port_output_data_r <= RST_POD;
      end else begin
         port_output_data_r <= port_output_data_nxt;
      end
   end

   assign PATTERN_OUT = port_output_data_r;

   // Read mux, unmapped addresses read zero
   always_comb begin
      rdata_nxt = RDATA_IDLE;
      if (bus.rd && active) begin
         case (bus.addr)
            ADDR_POD_HI: rdata_nxt = port_output_data_r[15:8];
            ADDR_POD_LO: rdata_nxt = port_output_data_r[7:0];
            ADDR_TRIG_SEL: rdata_nxt = trigger_select_r;
            ADDR_EN_HI: rdata_nxt = next_enable_r.hi;
            ADDR_EN_LO: rdata_nxt = next_enable_r.lo;
            ADDR_ND_HI_MAIN: rdata_nxt = rd_hi_main;
            ADDR_ND_LO_MAIN: rdata_nxt = rd_lo_main;
            ADDR_ND_HI_ALT: rdata_nxt = rd_hi_alt;
            ADDR_ND_LO_ALT: rdata_nxt = rd_lo_alt;
            default: rdata_nxt = RDATA_IDLE;
         endcase
      end
   end

   // Read data stands one cycle after the strobe only
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rdata_r <= RDATA_IDLE;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign BUS_RDATA = rdata_r;

   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   sequence s_lo_full_load;
      wr_nd_lo_main && same_trig_lo && !wr_trig;
   endsequence

   sequence s_lo_fire_all;
      fire[0] && fire[1] && (next_enable_r.lo == 8'hff) && !wr_pod_lo
         && !wr_nd_lo_main && !wr_nd_lo_alt;
   endsequence

   property p_load_then_transfer;
      s_lo_full_load ##1 s_lo_fire_all |=> port_output_data_r[7:0] == $past(bus.wdata, 2);
   endproperty
   a_load_then_transfer: assert property (p_load_then_transfer)
      else $error("low pair load and transfer mismatch");

   property p_pod_protect;
      (wr_pod_lo && fire[1:0] == 2'b00)
         |=> (port_output_data_r[7:0] & $past(next_enable_r.lo))
            == ($past(port_output_data_r[7:0]) & $past(next_enable_r.lo));
   endproperty
   a_pod_protect: assert property (p_pod_protect)
      else $error("enabled output bits changed by a write");

   property p_pod_write;
      (wr_pod_lo && next_enable_r.lo == 8'h00) |=> port_output_data_r[7:0] == $past(bus.wdata);
   endproperty
   a_pod_write: assert property (p_pod_write)
      else $error("free output bits not written");

   property p_standby_hold;
      STANDBY [*2] |-> $stable(next_data) && $stable(port_output_data_r)
         && $stable(trigger_select_r);
   endproperty
   a_standby_hold: assert property (p_standby_hold)
      else $error("contents changed in standby");

   property p_lo_alt_ones;
      (bus.rd && active && bus.addr == ADDR_ND_LO_ALT && same_trig_lo) |=> BUS_RDATA == 8'hff;
   endproperty
   a_lo_alt_ones: assert property (p_lo_alt_ones)
      else $error("shared low alternate did not read ones");

   property p_lo_split_read;
      (bus.rd && active && bus.addr == ADDR_ND_LO_MAIN && !same_trig_lo)
         |=> BUS_RDATA == {$past(next_data.lo[7:4]), 4'hf};
   endproperty
   a_lo_split_read: assert property (p_lo_split_read)
      else $error("split low main read wrong");

   property p_hi_alt_ignored;
      (wr_nd_hi_alt && same_trig_hi && !wr_trig) |=> $stable(next_data.hi);
   endproperty
   a_hi_alt_ignored: assert property (p_hi_alt_ignored)
      else $error("shared high alternate write took effect");

   property p_hi_split_write;
      (wr_nd_hi_alt && !same_trig_hi && !wr_trig)
         |=> next_data.hi == {$past(next_data.hi[7:4]), $past(bus.wdata[3:0])};
   endproperty
   a_hi_split_write: assert property (p_hi_split_write)
      else $error("split high alternate write wrong");

   property p_hi_same_read;
      (bus.rd && active && bus.addr == ADDR_ND_HI_MAIN && same_trig_hi)
         |=> BUS_RDATA == $past(next_data.hi);
   endproperty
   a_hi_same_read: assert property (p_hi_same_read)
      else $error("shared high main read wrong");

   property p_hi_transfer;
      (fire[3] && active && !wr_pod_hi)
         |=> (port_output_data_r[15:12] & $past(next_enable_r.hi[7:4]))
            == ($past(next_data.hi[7:4]) & $past(next_enable_r.hi[7:4]));
   endproperty
   a_hi_transfer: assert property (p_hi_transfer)
      else $error("group 3 transfer wrong");

   property p_sel_channel;
      (CMP_MATCH == (4'h1 << trigger_select_r[1:0]) && active) |-> fire[0];
   endproperty
   a_sel_channel: assert property (p_sel_channel)
      else $error("group 0 did not follow its selected channel");

   property p_disabled_hold;
      (!wr_pod_hi && !wr_pod_lo)
         |=> (port_output_data_r & ~$past(next_enable_r))
            == ($past(port_output_data_r) & ~$past(next_enable_r));
   endproperty
   a_disabled_hold: assert property (p_disabled_hold)
      else $error("disabled bit changed by a match");

   property p_idle_group;
      (!fire[0] && !wr_pod_lo) |=> $stable(port_output_data_r[3:0]);
   endproperty
   a_idle_group: assert property (p_idle_group)
      else $error("group 0 changed without its trigger");

endmodule

/* File: tb/ppn_timer_model.sv */
`timescale 1ns/1ps
module ppn_timer_model
   import ppn_pkg::*;
(
   // Clock
   input wire logic clk,
   // Compare-match pulses, channel 3 down to 0
   output logic [NUM_GRP-1:0] match
);
   initial match = '0;

   // One-clock pulse on the given channels, then quiet
   task automatic pulse(input logic [NUM_GRP-1:0] ch);
      @(posedge clk);
      match <= ch;
      @(posedge clk);
      match <= '0;
   endtask
endmodule

/* File: tb/tb_pulse_pattern_next_data_regs.sv */
`timescale 1ns/1ps
module tb_pulse_pattern_next_data_regs;
   import ppn_pkg::*;
   logic clk, resetn, bus_rd, bus_wr, standby;
   logic [ADDR_W-1:0] bus_addr;
   logic [DATA_W-1:0] bus_wdata, bus_rdata;
   logic [NUM_GRP-1:0] cmp_match;
   logic [15:0] pattern_out;
   int err_total = 0;
   int total_checks = 0;
   int cycles = 0;

   ppn_pattern_regs dut (
      .CLK(clk),
      .RESETN(resetn),
      .BUS_RD(bus_rd),
      .BUS_WR(bus_wr),
      .BUS_ADDR(bus_addr),
      .BUS_WDATA(bus_wdata),
      .BUS_RDATA(bus_rdata),
      .CMP_MATCH(cmp_match),
      .STANDBY(standby),
      .PATTERN_OUT(pattern_out)
   );

   ppn_timer_model u_tmr (
      .clk(clk),
      .match(cmp_match)
   );

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask

   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
      @(posedge clk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1;
      check({8'h00, bus_rdata}, {8'h00, exp});
   endtask

   task automatic co(input logic [15:0] exp);
      #1;
      check(pattern_out, exp);
   endtask

   task automatic print_verdict;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic t_reset;
      co(16'h0000);
      rdc(ADDR_ND_LO_MAIN, 8'h00);
      rdc(ADDR_ND_HI_MAIN, 8'h00);
      rdc(ADDR_ND_LO_ALT, 8'hff);
      rdc(ADDR_ND_HI_ALT, 8'hff);
      rdc(ADDR_TRIG_SEL, 8'hff);
      #20;
      check({8'h00, bus_rdata}, 16'h0000);
   endtask

   task automatic t_pod;
      wr(ADDR_POD_HI, 8'ha5);
      wr(ADDR_POD_LO, 8'h3c);
      co(16'ha53c);
      wr(ADDR_EN_LO, 8'hf0);
      wr(ADDR_POD_LO, 8'h00);
      co(16'ha530);
      rdc(ADDR_POD_LO, 8'h30);
   endtask

   task automatic t_shared;
      wr(ADDR_EN_HI, 8'hff);
      wr(ADDR_EN_LO, 8'hff);
      wr(ADDR_ND_LO_MAIN, 8'h69);
      wr(ADDR_ND_HI_MAIN, 8'h96);
      rdc(ADDR_ND_LO_MAIN, 8'h69);
      rdc(ADDR_ND_HI_MAIN, 8'h96);
      u_tmr.pulse(4'h1);
      co(16'ha530);
      u_tmr.pulse(4'h8);
      co(16'h9669);
      // Reserved addresses written as ones
      wr(ADDR_ND_LO_ALT, 8'hff);
      wr(ADDR_ND_HI_ALT, 8'hff);
      rdc(ADDR_ND_LO_ALT, 8'hff);
      rdc(ADDR_ND_HI_ALT, 8'hff);
      rdc(ADDR_ND_LO_MAIN, 8'h69);
      rdc(ADDR_ND_HI_MAIN, 8'h96);
      // Load followed at once by a match
      fork
         wr(ADDR_ND_LO_MAIN, 8'h5a);
         begin
            @(posedge clk);
            u_tmr.pulse(4'h8);
         end
      join
      co(16'h965a);
      wr(ADDR_ND_LO_MAIN, 8'h69);
      u_tmr.pulse(4'h8);
      co(16'h9669);
   endtask

   task automatic t_split;
      logic [15:0] exp_q [4];
      exp_q = '{16'h3669, 16'h3469, 16'h3419, 16'h3412};
      wr(ADDR_TRIG_SEL, 8'h1b);
      rdc(ADDR_ND_LO_MAIN, 8'h6f);
      rdc(ADDR_ND_LO_ALT, 8'hf9);
      rdc(ADDR_ND_HI_MAIN, 8'h9f);
      rdc(ADDR_ND_HI_ALT, 8'hf6);
      // Reserved nibbles written as ones
      wr(ADDR_ND_LO_MAIN, 8'h1f);
      wr(ADDR_ND_LO_ALT, 8'hf2);
      wr(ADDR_ND_HI_MAIN, 8'h3f);
      wr(ADDR_ND_HI_ALT, 8'hf4);
      for (int i = 0; i < 4; i++) begin
         u_tmr.pulse(4'(1 << i));
         co(exp_q[i]);
      end
      wr(ADDR_EN_LO, 8'h0f);
      wr(ADDR_ND_LO_ALT, 8'hf7);
      wr(ADDR_ND_LO_MAIN, 8'h8f);
      u_tmr.pulse(4'hc);
      co(16'h3417);
   endtask

   task automatic t_standby;
      wr(ADDR_ND_LO_ALT, 8'hf5);
      @(posedge clk);
      standby <= 1'b1;
      wr(ADDR_ND_LO_ALT, 8'hf0);
      rdc(ADDR_ND_LO_ALT, 8'h00);
      u_tmr.pulse(4'h8);
      co(16'h3417);
      @(posedge clk);
      standby <= 1'b0;
      rdc(ADDR_ND_LO_ALT, 8'hf5);
      rdc(ADDR_ND_HI_MAIN, 8'h3f);
      u_tmr.pulse(4'h8);
      co(16'h3415);
   endtask

   task automatic t_unmapped;
      wr(28'h5ffffe0, 8'h55);
      rdc(28'h5ffffe0, 8'h00);
   endtask

   task automatic t_rereset;
      @(posedge clk);
      resetn <= 1'b0;
      @(posedge clk);
      co(16'h0000);
      @(posedge clk);
      resetn <= 1'b1;
      rdc(ADDR_ND_HI_MAIN, 8'h00);
      rdc(ADDR_ND_LO_MAIN, 8'h00);
      rdc(ADDR_TRIG_SEL, 8'hff);
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_total++;
         print_verdict();
      end
   end

   initial begin
      resetn = 1'b0;
      bus_rd = 1'b0;
      bus_wr = 1'b0;
      standby = 1'b0;
      bus_addr = '0;
      bus_wdata = '0;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_pod();
      t_shared();
      t_split();
      t_standby();
      t_unmapped();
      t_rereset();
      print_verdict();
   end
endmodule
